/* File: pkg/iox_defs.vh */
// constants for the i2c octal io expander register block
`ifndef IOX_DEFS_VH
`define IOX_DEFS_VH
`define IOX_ADDR_FIXED    5'h1C
`define IOX_REG_INPUT     2'h0
`define IOX_REG_OUTPUT    2'h1
`define IOX_REG_INVERT    2'h2
`define IOX_REG_DIR       2'h3
`define IOX_RST_OUTPUT    8'hFF
`define IOX_RST_INVERT    8'h00
`define IOX_RST_DIR       8'hFF
`define IOX_RST_CMD       8'h00
`define IOX_RW_BIT        0
`endif

/* File: core/iox_regs.v */
// i2c slave register block of an eight bit io expander
// Operation
// R01: answer only address with fixed upper five bits and strap low bits
// R02: last address bit high means read, low means write
// R03: first write byte after address loads command pointer
// R04: pointer loads only in write transfers, never in reads
// R05: pointer holds between transactions
// R06: input register returns pin levels regardless of direction
// R07: writes to input register are discarded
// R08: latch bits drive pins only when configured as outputs
// R09: output register reads return latch contents
// R10: invert mask bit one inverts input value on read
// R11: direction bit one makes pin input, zero enables driver
// R12: write: address, command, then any number of stored data bytes
// R13: read: write command, repeated start, address with read bit
// R14: after repeated start selected register stays the same
// R15: read data captured on rising clock edge of ack bit
// R16: master nacks the final byte it reads
// R17: stop ends transfer at any byte and releases bus
// R18: matching address is acked by pulling data low
// R19: reset pin low restores all defaults
// R20: mismatched address is not acked, bus ignored until start
// R21: command bits above two select bits are ignored
`timescale 1ns/1ns
`include "iox_defs.vh"
module iox_regs
(
    // clock and reset
    input  wire       ref_clk,
    input  wire       rst,
    // reset pin, active low
    input  wire       resetN,
    // address straps
    input  wire       addr_strap_lo,
    input  wire       addr_strap_hi,
    // i2c bus
    input  wire       sclIn,
    input  wire       sdaIn,
    output reg        sdaOut_ff,
    output reg        sdaOe_ff,
    // port pins
    input  wire [7:0] port_pinsIn,
    output reg  [7:0] port_pinsOut_ff,
    output reg  [7:0] port_pinsOe_ff
);

////////////////////////////////////////////////////////////////////////////
localparam ST_IDLE = 6'h01;
localparam ST_ADDR = 6'h02;
localparam ST_AACK = 6'h04;
localparam ST_WRX  = 6'h08;
localparam ST_RTX  = 6'h10;
localparam ST_RACK = 6'h20;

reg  [1:0] sclSync_ff;
reg  [1:0] sdaSync_ff;
reg  [1:0] rstnSync_ff;
reg  [7:0] pinSync1_ff;
reg  [7:0] pinSync2_ff;
reg  [1:0] strapSync1_ff;
reg  [1:0] strapSync2_ff;
reg        sclD_ff;
reg        sdaD_ff;
reg  [5:0] state_ff;
reg  [3:0] bitCnt_ff;
reg  [7:0] shift_ff;
reg        isRead_ff;
reg        cmdDone_ff;
reg  [7:0] cmd_ff;
reg  [7:0] outLatch_ff;
reg  [7:0] invMask_ff;
reg  [7:0] dirMask_ff;
reg  [7:0] txByte_ff;
reg        drvLow_ff;

wire       sclS  = sclSync_ff[1];
wire       sdaS  = sdaSync_ff[1];
wire       sclRise = sclS & ~sclD_ff;
wire       sclFall = ~sclS & sclD_ff;
wire       startC = sclS & sclD_ff & sdaD_ff & ~sdaS;
wire       stopC  = sclS & sclD_ff & ~sdaD_ff & sdaS;
// reset pin acts like the internal reset
wire       anyRst = rst | ~rstnSync_ff[1];                              // R19
wire [6:0] myAddr = {`IOX_ADDR_FIXED, strapSync2_ff[1],
                     strapSync2_ff[0]};                                 // R01
wire [1:0] regSel = cmd_ff[1:0];                                        // R21

////////////////////////////////////////////////////////////////////////////
// two flops on every outside input except rst
always @(posedge ref_clk)
begin
    if (rst)
    begin
        sclSync_ff    <= 2'h3;
        sdaSync_ff    <= 2'h3;
        rstnSync_ff   <= 2'h0;
        pinSync1_ff   <= 8'h00;
        pinSync2_ff   <= 8'h00;
        strapSync1_ff <= 2'h0;
        strapSync2_ff <= 2'h0;
        sclD_ff       <= 1'b1;
        sdaD_ff       <= 1'b1;
    end
    else
    begin
        sclSync_ff    <= {sclSync_ff[0], sclIn};
        sdaSync_ff    <= {sdaSync_ff[0], sdaIn};
        rstnSync_ff   <= {rstnSync_ff[0], resetN};
        pinSync1_ff   <= port_pinsIn;
        pinSync2_ff   <= pinSync1_ff;
        strapSync1_ff <= {addr_strap_hi, addr_strap_lo};
        strapSync2_ff <= strapSync1_ff;
        sclD_ff       <= sclS;
        sdaD_ff       <= sdaS;
    end
end

////////////////////////////////////////////////////////////////////////////
// register read mux
reg [7:0] rdData;
always @*
begin
    rdData = 8'h00;
    case (regSel)
        `IOX_REG_INPUT:  rdData = pinSync2_ff ^ invMask_ff;          // R06 R10
        `IOX_REG_OUTPUT: rdData = outLatch_ff;                          // R09
        `IOX_REG_INVERT: rdData = invMask_ff;
        `IOX_REG_DIR:    rdData = dirMask_ff;
        default:         rdData = 8'h00;
    endcase
end

////////////////////////////////////////////////////////////////////////////
// bus state machine; data line only changes while the clock is low
always @(posedge ref_clk)
begin
    if (anyRst)
    begin
        state_ff    <= ST_IDLE;
        bitCnt_ff   <= 4'h0;
        shift_ff    <= 8'h00;
        isRead_ff   <= 1'b0;
        cmdDone_ff  <= 1'b0;
        cmd_ff      <= `IOX_RST_CMD;
        outLatch_ff <= `IOX_RST_OUTPUT;
        invMask_ff  <= `IOX_RST_INVERT;
        dirMask_ff  <= `IOX_RST_DIR;
        txByte_ff   <= 8'h00;
        drvLow_ff   <= 1'b0;
    end
    else if (stopC)
    begin
        state_ff  <= ST_IDLE;                                           // R17
        drvLow_ff <= 1'b0;
    end
    else if (startC)
    begin
        // repeated start keeps the pointer untouched                   // R14
        state_ff  <= ST_ADDR;
        bitCnt_ff <= 4'h0;
        drvLow_ff <= 1'b0;
    end
    else
    begin
        case (state_ff)
            ST_IDLE:
            begin
                drvLow_ff <= 1'b0;                                      // R20
            end
            ST_ADDR:
            begin
                if (sclRise)
                begin
                    shift_ff  <= {shift_ff[6:0], sdaS};
                    bitCnt_ff <= bitCnt_ff + 4'h1;
                end
                else if (sclFall && bitCnt_ff == 4'h8)
                begin
                    if (shift_ff[7:1] == myAddr)
                    begin
                        drvLow_ff  <= 1'b1;                             // R18
                        isRead_ff  <= shift_ff[`IOX_RW_BIT];            // R02
                        cmdDone_ff <= 1'b0;
                        state_ff   <= ST_AACK;
                    end
                    else
                    begin
                        state_ff <= ST_IDLE;                            // R20
                    end
                end
            end
            ST_AACK, ST_RACK:
            begin
                // ack rising edge captures read data                   // R15
                if (sclRise)
                begin
                    if (state_ff == ST_RACK && sdaS)
                    begin
                        state_ff <= ST_IDLE;                            // R16
                    end
                    else
                    begin
                        txByte_ff <= rdData;
                    end
                end
                else if (sclFall)
                begin
                    bitCnt_ff <= 4'h0;
                    if (isRead_ff)
                    begin
                        state_ff  <= ST_RTX;                            // R13
                        drvLow_ff <= ~txByte_ff[7];
                    end
                    else
                    begin
                        state_ff  <= ST_WRX;
                        drvLow_ff <= 1'b0;
                    end
                end
            end
            ST_WRX:
            begin
                // ack bit has count 8 or 9 and must not shift in
                if (sclRise && bitCnt_ff < 4'h8)
                begin
                    shift_ff  <= {shift_ff[6:0], sdaS};
                    bitCnt_ff <= bitCnt_ff + 4'h1;
                end
                else if (sclFall && bitCnt_ff == 4'h8)
                begin
                    drvLow_ff <= 1'b1;
                    bitCnt_ff <= 4'h9;
                    if (!cmdDone_ff)
                    begin
                        cmd_ff     <= shift_ff;                     // R03 R04
                        cmdDone_ff <= 1'b1;
                    end
                    else
                    begin
                        case (regSel)                                   // R12
                            `IOX_REG_OUTPUT: outLatch_ff <= shift_ff;
                            `IOX_REG_INVERT: invMask_ff  <= shift_ff;
                            `IOX_REG_DIR:    dirMask_ff  <= shift_ff;
                            default:         outLatch_ff <= outLatch_ff; // R07
                        endcase
                    end
                end
                else if (sclFall && bitCnt_ff == 4'h9)
                begin
                    drvLow_ff <= 1'b0;
                    bitCnt_ff <= 4'h0;
                end
            end
            ST_RTX:
            begin
                if (sclFall)
                begin
                    if (bitCnt_ff == 4'h7)
                    begin
                        drvLow_ff <= 1'b0;
                        state_ff  <= ST_RACK;
                    end
                    else
                    begin
                        drvLow_ff <= ~txByte_ff[3'h6 - bitCnt_ff[2:0]];
                        bitCnt_ff <= bitCnt_ff + 4'h1;
                    end
                end
            end
            default:
            begin
                state_ff <= ST_IDLE;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// outputs registered; pointer persists since only writes touch it  R05
always @(posedge ref_clk)
begin
    if (anyRst)
    begin
        sdaOut_ff       <= 1'b0;
        sdaOe_ff        <= 1'b0;
        port_pinsOut_ff <= `IOX_RST_OUTPUT;
        port_pinsOe_ff  <= 8'h00;
    end
    else
    begin
        sdaOut_ff       <= 1'b0;
        sdaOe_ff        <= drvLow_ff;
        port_pinsOut_ff <= outLatch_ff;                                 // R08
        port_pinsOe_ff  <= ~dirMask_ff;                                 // R11
    end
end

endmodule

/* File: verification/iox_regs_props.sv */
// checker for the io expander register block
`timescale 1ns/1ns
module iox_regs_props
(
    // clock and reset
    input wire       ref_clk,
    input wire       rst,
    input wire       resetN,
    // straps and bus
    input wire       addr_strap_lo,
    input wire       addr_strap_hi,
    input wire       sclIn,
    input wire       sdaIn,
    input wire       sdaOut_ff,
    input wire       sdaOe_ff,
    // port pins
    input wire [7:0] port_pinsIn,
    input wire [7:0] port_pinsOut_ff,
    input wire [7:0] port_pinsOe_ff
);
default clocking cb @(posedge ref_clk); endclocking
default disable iff (rst);
////////////////////////////////////////
sequence s_idle;
    (sclIn && sdaIn && resetN) [*8];
endsequence
sequence s_pin_rst;
    (!resetN) [*4];
endsequence
property p_od; sdaOut_ff == 1'b0; endproperty
a_od: assert property (p_od) else $error("data out high");
property p_rst; $fell(rst) |-> port_pinsOe_ff == 8'h00
    && port_pinsOut_ff == 8'hFF && !sdaOe_ff; endproperty
a_rst: assert property (p_rst) else $error("bad reset value");
property p_pin_rst; s_pin_rst |=> port_pinsOut_ff == 8'hFF
    && port_pinsOe_ff == 8'h00; endproperty
a_pin_rst: assert property (p_pin_rst) else $error("pin reset");
property p_pin_sda; (!resetN) [*5] |-> !sdaOe_ff; endproperty
a_pin_sda: assert property (p_pin_sda) else $error("bus in reset");
// data may only move while the serial clock is low
property p_hold; sclIn && $past(sclIn) && $past(sclIn, 2)
    |-> $stable(sdaOe_ff); endproperty
a_hold: assert property (p_hold) else $error("data moved");
property p_ack; $rose(sdaOe_ff) |-> sdaOe_ff [*6]; endproperty
a_ack: assert property (p_ack) else $error("drive too short");
property p_rel; $rose(sdaOe_ff) |-> ##[1:90] !sdaOe_ff; endproperty
a_rel: assert property (p_rel) else $error("bus held");
property p_quiet; s_idle |=> $stable(port_pinsOut_ff)
    && $stable(port_pinsOe_ff); endproperty
a_quiet: assert property (p_quiet) else $error("idle change");
endmodule
bind iox_regs iox_regs_props iox_regs_props_inst
(
    .ref_clk(ref_clk), .rst(rst), .resetN(resetN),
    .addr_strap_lo(addr_strap_lo), .addr_strap_hi(addr_strap_hi),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut_ff(sdaOut_ff),
    .sdaOe_ff(sdaOe_ff), .port_pinsIn(port_pinsIn),
    .port_pinsOut_ff(port_pinsOut_ff), .port_pinsOe_ff(port_pinsOe_ff)
);

/* File: verification/iox_master.sv */
// bus master model for the serial clock and data lines
`timescale 1ns/1ns
module iox_master
(
    // clock and bus
    input  wire ref_clk,
    input  wire sdaW,
    output reg  scl,
    output reg  sdaM
);
integer i;
// clock stands high between frames
initial
begin
    scl = 1'b1;
    sdaM = 1'b1;
end
////////////////////////////////////////
task hp;
    repeat (4) @(negedge ref_clk);
endtask
task bitx(input b, output r);
begin
    sdaM = b;
    hp;
    scl = 1'b1;
    hp;
    r = sdaW;
    scl = 1'b0;
end
endtask
task start;
begin
    sdaM = 1'b1;
    hp;
    scl = 1'b1;
    hp;
    sdaM = 1'b0;
    hp;
    scl = 1'b0;
end
endtask
task stop;
begin
    sdaM = 1'b0;
    hp;
    scl = 1'b1;
    hp;
    sdaM = 1'b1;
    hp;
end
endtask
// m high on a read byte is the final nack
task xfer(input [7:0] d, input m, output [7:0] q, output a);
begin
    for (i = 7; i >= 0; i = i - 1)
        bitx(d[i], q[i]);
    bitx(m, a);
end
endtask
endmodule

/* File: verification/iox_regs_tb_top.sv */
// self-checking bench for the io expander register block
`timescale 1ns/1ns
`include "iox_defs.vh"
`define CHK(n, e, s) begin n_tests = n_tests + 1; if ((s) !== (e)) \
begin fails = fails + 1; $display("Error %s exp %h got %h", n, e, s); end end
module iox_regs_tb_top;
reg        ref_clk = 1'b0;
reg        rst = 1'b1;
reg        resetN = 1'b1;
reg  [1:0] strap = 2'h2;
reg  [7:0] ext = 8'h00;
reg  [7:0] q;
reg        ak;
integer    fails = 0;
integer    n_tests = 0;
integer    cyc = 0;
integer    s;
wire       scl;
wire       sdaM;
wire       sdaOe;
wire [7:0] pOut;
wire [7:0] pOe;
// open drain data line with pull-up
wire       sdaW = sdaM & ~sdaOe;
wire [7:0] pins = (pOe & pOut) | (~pOe & ext);
always #5 ref_clk = ~ref_clk;
iox_regs iox_regs_inst
(
    .ref_clk(ref_clk), .rst(rst), .resetN(resetN),
    .addr_strap_lo(strap[0]), .addr_strap_hi(strap[1]),
    .sclIn(scl), .sdaIn(sdaW), .sdaOut_ff(), .sdaOe_ff(sdaOe),
    .port_pinsIn(pins), .port_pinsOut_ff(pOut), .port_pinsOe_ff(pOe)
);
iox_master iox_master_inst
(
    .ref_clk(ref_clk), .sdaW(sdaW), .scl(scl), .sdaM(sdaM)
);
////////////////////////////////////////
task sb(input [7:0] d, input m);
    iox_master_inst.xfer(d, m, q, ak);
endtask
function [7:0] adr(input r);
    adr = {`IOX_ADDR_FIXED, strap, r};
endfunction
task wr(input [7:0] c, input [7:0] d);
begin
    iox_master_inst.start;
    sb(adr(0), 1);
    `CHK("addr ack", 1'b0, ak);
    sb(c, 1);
    sb(d, 1);
    iox_master_inst.stop;
end
endtask
task cr(input [7:0] c, input [7:0] e);
begin
    iox_master_inst.start;
    sb(adr(0), 1);
    sb(c, 1);
    iox_master_inst.start;
    sb(adr(1), 1);
    sb(8'hFF, 1);
    iox_master_inst.stop;
    `CHK("read", e, q);
end
endtask
task t_main;
begin
    cr(8'h02, `IOX_RST_INVERT);
    cr(8'h03, `IOX_RST_DIR);
    cr(8'h01, `IOX_RST_OUTPUT);
    `CHK("pin oe", 8'h00, pOe);
    wr(8'h01, 8'h5A);
    wr(8'h03, 8'hF0);
    `CHK("pin oe", 8'h0F, pOe);
    `CHK("pin out", 8'h5A, pOut);
    ext = 8'h3C;
    cr(8'h00, 8'h3A);
    cr(8'h01, 8'h5A);
    wr(8'h02, 8'h81);
    cr(8'h00, 8'hBB);
    iox_master_inst.start;
    sb(adr(1), 1);
    sb(8'hFF, 0);
    `CHK("burst 1", 8'hBB, q);
    sb(8'hFF, 1);
    `CHK("burst 2", 8'hBB, q);
    iox_master_inst.stop;
end
endtask
task t_misc;
begin
    wr(8'h00, 8'h12);
    cr(8'h00, 8'hBB);
    cr(8'h01, 8'h5A);
    wr(8'hFD, 8'hC3);
    cr(8'hF1, 8'hC3);
    for (s = 0; s < 4; s = s + 1)
    begin
        strap = s[1:0];
        iox_master_inst.start;
        sb(adr(0), 1);
        `CHK("strap ack", 1'b0, ak);
        iox_master_inst.stop;
    end
    iox_master_inst.start;
    sb({`IOX_ADDR_FIXED, ~strap, 1'b0}, 1);
    `CHK("foreign", 1'b1, ak);
    sb(8'h01, 1);
    sb(8'h00, 1);
    iox_master_inst.stop;
    cr(8'h01, 8'hC3);
    resetN = 1'b0;
    repeat (6) @(negedge ref_clk);
    resetN = 1'b1;
    repeat (6) @(negedge ref_clk);
    `CHK("pin oe", 8'h00, pOe);
    cr(8'h01, `IOX_RST_OUTPUT);
end
endtask
task tally_and_finish;
begin
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
end
endtask
// cut a hang short well past the expected run length
always @(posedge ref_clk)
begin
    cyc = cyc + 1;
    if (cyc == 30000)
    begin
        fails = fails + 1;
        tally_and_finish;
    end
end
initial
begin
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    repeat (6) @(negedge ref_clk);
    t_main;
    t_misc;
    tally_and_finish;
end
endmodule
